// file: hdl/dtt_timer_ctrl.v
// Overview of operation
// - eight-bit timer counts only after its run bit is written one.
// - one-shot select zero: reload initial value at terminal count, keep counting.
// - one-shot select one: timer halts at terminal count.
// - terminal-count flag sets whenever the timer reaches terminal count.
// - terminal-count flag clears only by software writing one to it.
// - first count pulse after enable may be short and arrive any time.
// - capture enable set: interrupt on every capture byte load in demodulation.
// - timeout enable blocks timeout interrupts at zero, allows at one.
// - control bit 0 routes timer output to its pin; resets zero.
// - edge detector input chosen from two pins by input-select bit.
// - shared mode bit zero is transmit, one is demodulation.
// - transmit: output-select drives combined pin from port or combined timers.
// - demodulation edge field: 00 falling, 01 rising, 10 both, 11 reserved.
`timescale 1ns/1ns
`default_nettype none
`include "dtt_map.vh"
module dtt_timer_ctrl #(
  parameter WIDTH = 8
) (
  input  wire             clock,
  input  wire             rst_n,
  input  wire             clk_en,
  input  wire             reg_sel,
  input  wire             reg_wr,
  input  wire [7:0]       reg_addr,
  input  wire [7:0]       reg_wdata,
  output wire [7:0]       reg_rdata,
  input  wire             count_tick,
  input  wire [WIDTH-1:0] eight_bit_timer_init,
  input  wire             sixteen_bit_timer_out,
  input  wire             timer_out_port_data,
  input  wire             combined_out_port_data,
  input  wire             comparator_input_pin,
  input  wire             alt_demod_input_pin,
  output reg              timer_out_pin,
  output reg              combined_out_pin,
  output reg              capture_low_load,
  output reg              capture_high_load,
  output reg              timeout_irq,
  output reg              capture_irq,
  output wire [WIDTH-1:0] eight_bit_timer_count,
  output wire             eight_bit_timer_running
);
  reg  [7:0]       ctrl0_reg;
  reg  [7:0]       ctrl1_reg;
  reg  [WIDTH-1:0] cnt_reg;
  reg              run_reg;
  reg              t8_out_reg;
  reg              timeout_reg;
  reg              rise_flag_reg;
  reg              fall_flag_reg;
  reg              cap_phase_reg;

  wire wr0 = clk_en & reg_sel & reg_wr & (reg_addr == `DTT_ADDR_CTRL0);
  wire wr1 = clk_en & reg_sel & reg_wr & (reg_addr == `DTT_ADDR_CTRL1);
  wire demod = ctrl1_reg[`DTT_C1_MODE];
  wire [1:0] fn = {ctrl1_reg[`DTT_C1_FUNC_HI], ctrl1_reg[`DTT_C1_FUNC_LO]};

  wire demod_in = ctrl1_reg[`DTT_C1_OUT_SEL] ? alt_demod_input_pin : comparator_input_pin;
  wire e_rise;
  wire e_fall;

  dtt_edge_det u_edge (
    .clock (clock),
    .rst_n (rst_n),
    .clk_en(clk_en),
    .din   (demod_in),
    .rise  (e_rise),
    .fall  (e_fall)
  );

  // edge field qualifies captures; reserved code captures nothing
  wire take_rise = demod & e_rise & ((fn == `DTT_EDGE_RISE) | (fn == `DTT_EDGE_BOTH));
  wire take_fall = demod & e_fall & ((fn == `DTT_EDGE_FALL) | (fn == `DTT_EDGE_BOTH));
  wire capture   = take_rise | take_fall;

  // tick is accepted from the first cycle run is set, whatever its phase
  wire tick = clk_en & run_reg & count_tick;
  wire tc   = tick & (cnt_reg == {WIDTH{1'b0}});

  // write strobes already carry the clock enable
  always @(posedge clock) begin
    if (!rst_n) begin
      ctrl0_reg <= `DTT_CTRL0_RST;
    end else if (wr0) begin
      // timeout flag bit is status, kept separately
      ctrl0_reg <= reg_wdata;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      ctrl1_reg <= `DTT_CTRL1_RST;
    end else if (wr1) begin
      ctrl1_reg <= reg_wdata;
    end
  end

  // counter, run control and timer output
  reg [WIDTH-1:0] cnt_next;
  reg             run_next;
  reg             t8_out_next;

  // a ctrl0 write outranks a tick in the same cycle
  always @* begin
    cnt_next    = cnt_reg;
    run_next    = run_reg;
    t8_out_next = t8_out_reg;
    if (wr0 && reg_wdata[`DTT_C0_ENABLE]) begin
      run_next = 1'b1;
      cnt_next = eight_bit_timer_init;
      if (!demod) begin
        t8_out_next = ctrl1_reg[`DTT_C1_RISE];
      end
    end else if (wr0) begin
      // writing zero to the run bit stops the count
      run_next = 1'b0;
    end else if (tc) begin
      t8_out_next = ~t8_out_reg;
      if (ctrl0_reg[`DTT_C0_ONESHOT]) begin
        run_next = 1'b0;
      end else begin
        cnt_next = eight_bit_timer_init;
      end
    end else if (tick) begin
      cnt_next = cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      cnt_reg    <= {WIDTH{1'b0}};
      run_reg    <= 1'b0;
      t8_out_reg <= 1'b0;
    end else if (clk_en) begin
      cnt_reg    <= cnt_next;
      run_reg    <= run_next;
      t8_out_reg <= t8_out_next;
    end
  end

  // status flags: set beats a concurrent software clear
  always @(posedge clock) begin
    if (!rst_n) begin
      timeout_reg <= 1'b0;
    end else if (clk_en) begin
      if (tc) begin
        timeout_reg <= 1'b1;
      end else if (wr0 && reg_wdata[`DTT_C0_TIMEOUT]) begin
        timeout_reg <= 1'b0;
      end
    end
  end

  // edge flags clear by a written one, and only in demodulation
  always @(posedge clock) begin
    if (!rst_n) begin
      rise_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (take_rise) begin
        rise_flag_reg <= 1'b1;
      end else if (wr1 && demod && reg_wdata[`DTT_C1_RISE]) begin
        rise_flag_reg <= 1'b0;
      end
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      fall_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (take_fall) begin
        fall_flag_reg <= 1'b1;
      end else if (wr1 && demod && reg_wdata[`DTT_C1_FALL]) begin
        fall_flag_reg <= 1'b0;
      end
    end
  end

  // capture strobes alternate low then high byte
  always @(posedge clock) begin
    if (!rst_n) begin
      cap_phase_reg     <= 1'b0;
      capture_low_load  <= 1'b0;
      capture_high_load <= 1'b0;
    end else if (clk_en) begin
      capture_low_load  <= capture & ~cap_phase_reg;
      capture_high_load <= capture & cap_phase_reg;
      // phase restarts in transmit so the next capture lands low
      if (!demod) begin
        cap_phase_reg <= 1'b0;
      end else if (capture) begin
        cap_phase_reg <= ~cap_phase_reg;
      end
    end
  end

  // interrupt requests, one cycle each
  always @(posedge clock) begin
    if (!rst_n) begin
      capture_irq <= 1'b0;
      timeout_irq <= 1'b0;
    end else if (clk_en) begin
      capture_irq <= capture & ctrl0_reg[`DTT_C0_CAP_IE];
      // pulse only on the flag's rising
      timeout_irq <= tc & ~timeout_reg & ctrl0_reg[`DTT_C0_TO_IE];
    end
  end

  // pin outputs registered to keep them glitch free
  reg comb;
  always @* begin
    case (fn)
      `DTT_FN_AND:  comb = t8_out_reg & sixteen_bit_timer_out;
      `DTT_FN_OR:   comb = t8_out_reg | sixteen_bit_timer_out;
      `DTT_FN_NOR:  comb = ~(t8_out_reg | sixteen_bit_timer_out);
      `DTT_FN_NAND: comb = ~(t8_out_reg & sixteen_bit_timer_out);
      default:      comb = t8_out_reg & sixteen_bit_timer_out;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      timer_out_pin <= 1'b0;
    end else if (clk_en) begin
      timer_out_pin <= ctrl0_reg[`DTT_C0_PIN_SEL] ? t8_out_reg : timer_out_port_data;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      combined_out_pin <= 1'b0;
    end else if (clk_en) begin
      if (!demod && ctrl1_reg[`DTT_C1_OUT_SEL]) begin
        combined_out_pin <= comb;
      end else begin
        combined_out_pin <= combined_out_port_data;
      end
    end
  end

  // read data is combinational; unmapped addresses read zero
  reg [7:0] rdata_mux;
  always @* begin
    rdata_mux = 8'h00;
    case (reg_addr)
      `DTT_ADDR_CTRL0: begin
        rdata_mux[`DTT_C0_ENABLE]   = run_reg;
        rdata_mux[`DTT_C0_ONESHOT]  = ctrl0_reg[`DTT_C0_ONESHOT];
        rdata_mux[`DTT_C0_TIMEOUT]  = timeout_reg;
        rdata_mux[`DTT_C0_CLKSEL_HI] = ctrl0_reg[`DTT_C0_CLKSEL_HI];
        rdata_mux[`DTT_C0_CLKSEL_LO] = ctrl0_reg[`DTT_C0_CLKSEL_LO];
        rdata_mux[`DTT_C0_CAP_IE]   = ctrl0_reg[`DTT_C0_CAP_IE];
        rdata_mux[`DTT_C0_TO_IE]    = ctrl0_reg[`DTT_C0_TO_IE];
        rdata_mux[`DTT_C0_PIN_SEL]  = ctrl0_reg[`DTT_C0_PIN_SEL];
      end
      `DTT_ADDR_CTRL1: begin
        rdata_mux = ctrl1_reg;
        // in demodulation the low two bits report edge flags
        if (demod) begin
          rdata_mux[`DTT_C1_RISE] = rise_flag_reg;
          rdata_mux[`DTT_C1_FALL] = fall_flag_reg;
        end
      end
      default: begin
        rdata_mux = 8'h00;
      end
    endcase
  end

  assign reg_rdata = rdata_mux;
  assign eight_bit_timer_count   = cnt_reg;
  assign eight_bit_timer_running = run_reg;
endmodule
`default_nettype wire

// file: hdl/dtt_map.vh
`ifndef DTT_MAP_VH
`define DTT_MAP_VH
// register addresses on the expanded register bank
`define DTT_ADDR_CTRL0      8'h00
`define DTT_ADDR_CTRL1      8'h01
// eight_bit_timer_ctrl fields
`define DTT_C0_ENABLE       7
`define DTT_C0_ONESHOT      6
`define DTT_C0_TIMEOUT      5
`define DTT_C0_CLKSEL_HI    4
`define DTT_C0_CLKSEL_LO    3
`define DTT_C0_CAP_IE       2
`define DTT_C0_TO_IE        1
`define DTT_C0_PIN_SEL      0
// shared_timer_ctrl fields
`define DTT_C1_MODE         7
`define DTT_C1_OUT_SEL      6
`define DTT_C1_FUNC_HI      5
`define DTT_C1_FUNC_LO      4
`define DTT_C1_SUB_HI       3
`define DTT_C1_SUB_LO       2
`define DTT_C1_RISE         1
`define DTT_C1_FALL         0
// reset values
`define DTT_CTRL0_RST       8'h00
`define DTT_CTRL1_RST       8'h00
// edge field codes in demodulation mode
`define DTT_EDGE_FALL       2'h0
`define DTT_EDGE_RISE       2'h1
`define DTT_EDGE_BOTH       2'h2
// combine codes in transmit mode
`define DTT_FN_AND          2'h0
`define DTT_FN_OR           2'h1
`define DTT_FN_NOR          2'h2
`define DTT_FN_NAND         2'h3
`endif

// file: hdl/dtt_edge_det.v
`timescale 1ns/1ns
`default_nettype none
// edge detector on a synchronous input; one-cycle pulses
module dtt_edge_det (
  input  wire clock,
  input  wire rst_n,
  input  wire clk_en,
  input  wire din,
  output wire rise,
  output wire fall
);
  reg prev_reg;
  // first sample after reset seeds history, no false edge
  reg seeded_reg;

  always @(posedge clock) begin
    if (!rst_n) begin
      prev_reg   <= 1'b0;
      seeded_reg <= 1'b0;
    end else if (clk_en) begin
      prev_reg   <= din;
      seeded_reg <= 1'b1;
    end
  end

  assign rise = clk_en & seeded_reg & din & ~prev_reg;
  assign fall = clk_en & seeded_reg & ~din & prev_reg;
endmodule
`default_nettype wire

// file: tb/dtt_timer_ctrl_checker.sv
`timescale 1ns/1ns
`default_nettype none
module dtt_chk #(
  parameter WIDTH = 8
) (
  input wire logic             clock,
  input wire logic             rst_n,
  input wire logic             clk_en,
  input wire logic             reg_sel,
  input wire logic             reg_wr,
  input wire logic [7:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic [7:0]       reg_rdata,
  input wire logic             count_tick,
  input wire logic [WIDTH-1:0] eight_bit_timer_init,
  input wire logic             timer_out_port_data,
  input wire logic             timer_out_pin,
  input wire logic             capture_low_load,
  input wire logic             capture_high_load,
  input wire logic             timeout_irq,
  input wire logic             capture_irq,
  input wire logic [WIDTH-1:0] eight_bit_timer_count,
  input wire logic             eight_bit_timer_running
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire w  = clk_en & reg_sel & reg_wr;
  wire a0 = reg_addr == 8'h00;
  wire go = clk_en & eight_bit_timer_running & count_tick;
  sequence s_term;
    go && eight_bit_timer_count == 0;
  endsequence
  sequence s_hit;
    s_term ##0 (a0 && !w);
  endsequence
  a_count_down: assert property (go && !w && eight_bit_timer_count != 0 |=>
    eight_bit_timer_count == $past(eight_bit_timer_count) - 1'b1) else $error("count step");
  a_reload_mod: assert property (s_hit ##0 !reg_rdata[6] |=> eight_bit_timer_running &&
    eight_bit_timer_count == $past(eight_bit_timer_init)) else $error("no reload");
  a_oneshot_halt: assert property (s_hit ##0 reg_rdata[6] |=> !eight_bit_timer_running)
    else $error("no halt");
  a_flag_set: assert property (s_hit ##1 a0 |-> reg_rdata[5])
    else $error("flag not set");
  a_flag_hold: assert property (a0 && reg_rdata[5] && !(w && reg_wdata[5]) ##1 a0 |-> reg_rdata[5])
    else $error("flag lost");
  a_irq_mask: assert property (s_hit ##0 !reg_rdata[5] |=> timeout_irq == $past(reg_rdata[1]))
    else $error("timeout irq mask");
  a_irq_cause: assert property (timeout_irq |-> $past(go && eight_bit_timer_count == 0))
    else $error("stray timeout irq");
  a_cap_irq: assert property (capture_irq |-> (capture_low_load || capture_high_load) &&
    (!a0 || reg_rdata[2])) else $error("capture irq");
  a_pin_port: assert property (clk_en && a0 && !w && !reg_rdata[0] |=>
    timer_out_pin == $past(timer_out_port_data)) else $error("pin not port");
endmodule
bind dtt_timer_ctrl dtt_chk #(.WIDTH(WIDTH)) u_chk (.clock, .rst_n, .clk_en, .reg_sel, .reg_wr,
  .reg_addr, .reg_wdata, .reg_rdata, .count_tick, .eight_bit_timer_init, .timer_out_port_data,
  .timer_out_pin, .capture_low_load, .capture_high_load, .timeout_irq, .capture_irq,
  .eight_bit_timer_count, .eight_bit_timer_running);
`default_nettype wire

// file: tb/dtt_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module dtt_pin_model (
  input  wire logic clock,
  input  wire logic sel,
  input  wire logic lvl,
  output var  logic comparator_input_pin,
  output var  logic alt_demod_input_pin
);
  logic tog = 1'b0;
  initial {comparator_input_pin, alt_demod_input_pin} = 2'b00;
  always @(posedge clock) begin
    tog <= ~tog;
    comparator_input_pin <= sel ? tog : lvl;
    alt_demod_input_pin <= sel ? lvl : tog;
  end
endmodule
`default_nettype wire

// file: tb/test_dual_timer_transmit_demodulate.sv
`timescale 1ns/1ns
`default_nettype none
module test_dual_timer_transmit_demodulate;
  logic       clock = 0, rst_n = 0, clk_en = 1, reg_sel = 0, reg_wr = 0, count_tick = 0;
  logic       sixteen_bit_timer_out = 0, timer_out_port_data = 0, combined_out_port_data = 0;
  logic       sel = 0, lvl = 0, comparator_input_pin, alt_demod_input_pin, timer_out_pin;
  logic       combined_out_pin, capture_low_load, capture_high_load, timeout_irq, capture_irq;
  logic       eight_bit_timer_running;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, eight_bit_timer_init = 0;
  logic [7:0] eight_bit_timer_count, v;
  int         n_fail = 0, checks = 0, ncap, nirq, m_cnt, m_run, m_flag, m_irq, e;
  logic [31:0] rs = 32'haac4;
  dtt_timer_ctrl u_dut (.clock, .rst_n, .clk_en, .reg_sel, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .count_tick, .eight_bit_timer_init, .sixteen_bit_timer_out,
    .timer_out_port_data, .combined_out_port_data, .comparator_input_pin, .alt_demod_input_pin,
    .timer_out_pin, .combined_out_pin, .capture_low_load, .capture_high_load, .timeout_irq,
    .capture_irq, .eight_bit_timer_count, .eight_bit_timer_running);
  dtt_pin_model u_pins (.clock, .sel, .lvl, .comparator_input_pin, .alt_demod_input_pin);
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    ncap += capture_low_load + capture_high_load;
    nirq += capture_irq;
  end
  function logic [31:0] nx(input logic [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic cf(input logic a, input logic b, input logic [1:0] f);
    cf = f[1] ^ ((f[0] ^ f[1]) ? (a | b) : (a & b));
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    {reg_sel, reg_wr, clk_en, reg_addr, reg_wdata} = {3'b111, a, d};
    @(negedge clock);
    {reg_sel, reg_wr, reg_addr} = 10'h0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    reg_addr = a;
    #1 chk(reg_rdata, exp, nm);
    reg_addr = 8'h00;
  endtask
  task results;
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // budget: whole sequence needs under 2000 cycles
  initial begin
    #40000 n_fail++;
    results;
  end
  initial begin
    repeat (10) @(negedge clock);
    rst_n = 1;
    wr(8'h05, 8'hff);
    rd(8'h00, 8'h00, "ctrl0 rst");
    rd(8'h01, 8'h00, "ctrl1 rst");
    rd(8'h05, 8'h00, "unmapped");
    for (int k = 0; k < 4; k++) begin
      {count_tick, clk_en} = 2'b01;
      eight_bit_timer_init = 8'(2 * k);
      wr(8'h00, 8'h20);
      wr(8'h00, {1'b1, k[1], 4'h0, k[0], 1'b0});
      {m_cnt, m_run, m_flag, m_irq} = {24'h0, eight_bit_timer_init, 32'h1, 64'h0};
      repeat (60) begin
        chk(eight_bit_timer_count, m_cnt, "count");
        chk(eight_bit_timer_running, m_run, "run");
        chk(timeout_irq, m_irq, "tirq");
        rd(8'h00, {m_run[0], k[1], m_flag[0], 3'h0, k[0], 1'b0}, "ctrl0");
        rs = nx(rs);
        {count_tick, timer_out_port_data} = rs[1:0];
        clk_en = rs[3] | rs[4] | m_irq[0];
        m_irq = 0;
        if (clk_en && m_run && count_tick && m_cnt == 0) begin
          {m_irq, m_flag} = {k[0] && !m_flag, 32'h1};
          if (k[1]) m_run = 0;
          else m_cnt = eight_bit_timer_init;
        end else if (clk_en && m_run && count_tick) m_cnt--;
        @(negedge clock);
      end
    end
    {count_tick, clk_en} = 2'b01;
    wr(8'h00, 8'h00);
    rd(8'h00, {2'h0, m_flag[0], 5'h0}, "flag kept");
    for (int k = 0; k < 32; k++) begin
      {sixteen_bit_timer_out, combined_out_port_data} = k[2:1];
      v = {1'b0, k[4], k[3:2], 2'b0, k[0], 1'b0};
      wr(8'h00, 8'h01);
      wr(8'h01, v);
      wr(8'h00, 8'h81);
      reg_addr = 8'h01;
      repeat (2) @(negedge clock);
      chk(reg_rdata, v, "ctrl1");
      chk(timer_out_pin, k[0], "tpin");
      chk(combined_out_pin, k[4] ? cf(k[0], k[2], k[3:2]) : k[1], "cpin");
      reg_addr = 8'h00;
    end
    wr(8'h00, 8'h04);
    for (int k = 0; k < 8; k++) begin
      {sel, e} = {k[2], 32'(k[1:0])};
      wr(8'h01, {1'b1, k[2], k[1:0], 4'h3});
      repeat (4) @(negedge clock);
      {ncap, nirq, lvl} = 65'h0;
      repeat (6) @(negedge clock);
      lvl = 1;
      repeat (6) @(negedge clock);
      lvl = 0;
      repeat (6) @(negedge clock);
      v = {6'h0, e == 1 || e == 2, e == 0 || e == 2};
      chk(ncap, v[0] + v[1], "captures");
      chk(nirq, v[0] + v[1], "cap irq");
      rd(8'h01, {1'b1, k[2], k[1:0], 2'h0, v[1:0]}, "edge flags");
    end
    results;
  end
endmodule
`default_nettype wire
